// ==== pmsa_regs.svh ====
// Offsets, field positions, reset values and timing of the resolver.
// Assumes inclusion by bare name from the resolver module and the bench.
`ifndef PMSA_REGS_SVH
`define PMSA_REGS_SVH

// Register offsets
`define OFS_CAP      12'h000
`define OFS_ENTRY    12'h004
`define OFS_ATTR     12'h008
`define OFS_TTYPE    12'h00c
`define OFS_REQ      12'h010
`define OFS_RESULT   12'h014
`define OFS_STATUS   12'h018

// Capability bits
`define CAP_MTYPE    0
`define CAP_SNPCTL   1
`define CAP_RESET    32'h0000_0003

// Entry word holding bits 95:64
`define ENT_RSVD_HI  31
`define ENT_RSVD_LO  27
`define ENT_ETE      26
`define ENT_CDIS     25
`define ENT_PSNP     24
`define ENTRY_RESET  32'h0000_0000
`define ATTR_RESET   32'h0000_0000

// Request fields
`define REQ_COH      0
`define REQ_SLOT_LO  1
`define REQ_EMT_LO   4
`define REQ_SNOOP    7
`define REQ_WRITE    8
`define REQ_HIT      9
`define REQ_SHARED   10

// Status bits
`define ST_DONE      0
`define ST_RSVD      1
`define ST_BADCODE   2
`define ST_BADTT     3

// Evaluation latency in cycles
`define EVAL_CYCLES  1

`endif

// ==== pmsa_pkg.sv ====
// Types shared by the memory-type resolver files.
// Assumes nothing outside itself.
package pmsa_pkg;

   typedef enum logic [2:0] {
      MT_UC  = 3'h0,
      MT_WC  = 3'h1,
      MT_WT  = 3'h4,
      MT_WP  = 3'h5,
      MT_WB  = 3'h6,
      MT_UCM = 3'h7
   } memtype_t;

   typedef enum logic [2:0] {
      TT_FIRST  = 3'h1,
      TT_SECOND = 3'h2,
      TT_NESTED = 3'h3,
      TT_PASS   = 3'h4
   } ttype_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h1,
      ST_EVAL = 2'h2
   } state_t;

endpackage : pmsa_pkg

// ==== attr_slot_decode.sv ====
// Decodes one memory-type attribute code.
// Assumes a code from a page attribute slot or a leaf extended field.
`timescale 1ns/1ps
`default_nettype none
module attr_slot_decode #(
   parameter int CODE_W = 3
) (
   // Code in
   input  wire logic [CODE_W-1:0] code,
   // Decoded
   output logic                   valid,
   output pmsa_pkg::memtype_t     memtype
);
   if (CODE_W < 3) begin : g_code_check
      $error("attr_slot_decode: CODE_W below 3");
   end

   logic upper_set;

   always_comb begin
      upper_set = (CODE_W > 3) ? (code >> 3) != '0 : 1'b0;
      valid     = 1'b0;
      memtype   = pmsa_pkg::MT_UC;
      if (!upper_set) begin
         case (code[2:0])
            3'h0: begin valid = 1'b1; memtype = pmsa_pkg::MT_UC;  end
            3'h1: begin valid = 1'b1; memtype = pmsa_pkg::MT_WC;  end
            3'h4: begin valid = 1'b1; memtype = pmsa_pkg::MT_WT;  end
            3'h5: begin valid = 1'b1; memtype = pmsa_pkg::MT_WP;  end
            3'h6: begin valid = 1'b1; memtype = pmsa_pkg::MT_WB;  end
            3'h7: begin valid = 1'b1; memtype = pmsa_pkg::MT_UCM; end
            default: begin valid = 1'b0; memtype = pmsa_pkg::MT_UC; end
         endcase
      end
   end
endmodule : attr_slot_decode
`default_nettype wire

// ==== snoop_resolve.sv ====
// Resolves the snoop decision for one request.
// Assumes capability and entry bits already held in registers.
`timescale 1ns/1ps
`default_nettype none
module snoop_resolve (
   // Controls
   input  wire logic snpctl_support,
   input  wire logic page_snoop,
   input  wire logic req_snoop,
   // Result
   output logic      snoop,
   output logic      rsvd_fault
);
   // Without support the field is reserved: flag it, never act on it
   assign rsvd_fault = !snpctl_support && page_snoop;
   assign snoop      = (snpctl_support && page_snoop) || req_snoop;
endmodule : snoop_resolve
`default_nettype wire

// ==== pasid_memtype_snoop_attr.sv ====
// Memory-type and snoop resolver for one address-space table entry.
// Assumes an APB master on pclk; software loads the entry words, then
// writes a request word and reads the result once done is set.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmsa_regs.svh"
module pasid_memtype_snoop_attr #(
   parameter int SLOTS = 8
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Resolved request
   output logic [2:0]       eff_memtype,
   output logic             eff_snoop,
   output logic             result_done
);
   if (SLOTS != 8) begin : g_slots_check
      $error("pasid_memtype_snoop_attr: SLOTS must be 8");
   end

   // Registers
   logic [31:0]      cap;
   logic [31:0]      entry;
   logic [31:0]      attr_table;
   logic [2:0]       ttype;
   logic [10:0]      req;
   logic [12:0]      result;
   logic [3:0]       status;
   pmsa_pkg::state_t state;
   pmsa_pkg::state_t next_state;

   // Bus decode
   logic setup;
   logic wr;
   logic mapped;
   logic req_wr;
   logic st_wr;

   assign setup  = psel && !penable;
   assign wr     = psel && penable && pwrite;
   assign pready = 1'b1;

   always_comb begin
      case (paddr)
         `OFS_CAP, `OFS_ENTRY, `OFS_ATTR, `OFS_TTYPE,
         `OFS_REQ, `OFS_RESULT, `OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Unmapped address answers with an error, no state change
   assign pslverr = psel && penable && !mapped;
   assign req_wr  = wr && (paddr == `OFS_REQ);
   assign st_wr   = wr && (paddr == `OFS_STATUS);

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) res[8*b +: 8] = data[8*b +: 8];
      end
      return res;
   endfunction : merge

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap   <= `CAP_RESET;
         entry <= `ENTRY_RESET;
         attr_table <= `ATTR_RESET;
         ttype <= 3'h0;
      end else if (wr) begin
         case (paddr)
            `OFS_CAP:   cap   <= merge(cap, pwdata, pstrb) & 32'h0000_0003;
            `OFS_ENTRY: entry <= merge(entry, pwdata, pstrb);
            `OFS_ATTR:  attr_table <= merge(attr_table, pwdata, pstrb);
            `OFS_TTYPE: ttype <= pstrb[0] ? pwdata[2:0] : ttype;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req <= 11'h000;
      end else if (req_wr) begin
         req <= 11'(merge({21'h0, req}, pwdata, pstrb));
      end
   end

   // Evaluation sequencer
   always_comb begin
      case (state)
         pmsa_pkg::ST_IDLE: next_state = req_wr ? pmsa_pkg::ST_EVAL : pmsa_pkg::ST_IDLE;
         pmsa_pkg::ST_EVAL: next_state = pmsa_pkg::ST_IDLE;
         default:           next_state = pmsa_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state <= pmsa_pkg::ST_IDLE;
      else          state <= next_state;
   end

   // Field views
   logic       mtype_sup;
   logic       snoop_sup;
   logic       ete;
   logic       cache_dis;
   logic       psnp;
   logic       coh;
   logic [2:0] slot;
   logic [2:0] leaf_code;
   logic       is_write;
   logic       hit;
   logic       shared;
   logic [2:0] slot_code;

   assign mtype_sup = cap[`CAP_MTYPE];
   assign snoop_sup = cap[`CAP_SNPCTL];
   assign ete       = entry[`ENT_ETE];
   assign cache_dis = entry[`ENT_CDIS];
   assign psnp      = entry[`ENT_PSNP];
   assign coh       = req[`REQ_COH];
   assign slot      = req[`REQ_SLOT_LO +: 3];
   assign leaf_code = req[`REQ_EMT_LO +: 3];
   assign is_write  = req[`REQ_WRITE];
   assign hit       = req[`REQ_HIT];
   assign shared    = req[`REQ_SHARED];
   // Slots sit on nibble boundaries; the top bit of each nibble is unused
   assign slot_code = attr_table[{slot, 2'h0} +: 3];

   // Decoders
   logic               slot_ok;
   logic               leaf_ok;
   pmsa_pkg::memtype_t slot_type;
   pmsa_pkg::memtype_t leaf_type;
   logic               snoop_now;
   logic               snoop_fault;

   attr_slot_decode #(.CODE_W(3)) u_slot_dec (
      .code    (slot_code),
      .valid   (slot_ok),
      .memtype (slot_type)
   );

   attr_slot_decode #(.CODE_W(3)) u_leaf_dec (
      .code    (leaf_code),
      .valid   (leaf_ok),
      .memtype (leaf_type)
   );

   snoop_resolve u_snoop (
      .snpctl_support (snoop_sup),
      .page_snoop (psnp),
      .req_snoop  (req[`REQ_SNOOP]),
      .snoop      (snoop_now),
      .rsvd_fault (snoop_fault)
   );

   // Resolution
   logic               tt_ok;
   logic               ete_used;
   logic               rsvd_fault;
   logic               code_fault;
   logic               type_valid;
   logic               cache_on;
   pmsa_pkg::memtype_t next_type;

   always_comb begin
      case (ttype)
         3'h1, 3'h2, 3'h3, 3'h4: tt_ok = 1'b1;
         default: tt_ok = 1'b0;
      endcase
   end

   // Extended enable only counts where a second stage exists
   assign ete_used = mtype_sup && ete &&
                     (ttype == pmsa_pkg::TT_SECOND || ttype == pmsa_pkg::TT_NESTED);

   // Reserved fields checked even if the request would ignore them
   assign rsvd_fault = (!mtype_sup && (attr_table != 32'h0 || ete || cache_dis)) ||
                       (entry[`ENT_RSVD_HI:`ENT_RSVD_LO] != 5'h0) ||
                       snoop_fault;

   assign type_valid = coh && mtype_sup;
   assign cache_on   = !(cache_dis && type_valid);

   always_comb begin
      next_type  = pmsa_pkg::MT_UC;
      code_fault = 1'b0;
      if (type_valid) begin
         if (cache_dis) begin
            next_type = pmsa_pkg::MT_UC;
         end else if (ete_used) begin
            next_type  = leaf_type;
            code_fault = !leaf_ok;
         end else begin
            next_type  = slot_type;
            code_fault = !slot_ok;
         end
      end
   end

   // Result register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 13'h0000;
      end else if (state == pmsa_pkg::ST_EVAL) begin
         result[2:0] <= next_type;
         result[3]   <= type_valid;
         result[4]   <= snoop_now;
         result[5]   <= cache_on && !is_write && hit;
         result[6]   <= cache_on && !is_write && !hit;
         result[7]   <= cache_on && is_write && hit;
         result[8]   <= cache_on && is_write && !hit;
         result[9]   <= is_write && (!cache_on || shared || !hit);
         result[10]  <= cache_on && is_write && hit && shared &&
                        next_type == pmsa_pkg::MT_WB;
         result[11]  <= cache_on && is_write && hit && shared &&
                        next_type == pmsa_pkg::MT_WB;
         result[12]  <= ttype == pmsa_pkg::TT_NESTED;
      end
   end

   assign eff_memtype = result[2:0];
   assign eff_snoop   = result[4];

   // Status: hardware set wins over the write-one clear
   logic       eval_end;
   logic [3:0] set_bits;
   logic [3:0] clr_bits;

   assign eval_end = state == pmsa_pkg::ST_EVAL;
   assign set_bits = eval_end ? {!tt_ok, code_fault, rsvd_fault, 1'b1} : 4'h0;
   assign clr_bits = (st_wr && pstrb[0]) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 4'h0;
      end else begin
         status[3:1] <= set_bits[3:1] | (status[3:1] & ~clr_bits[3:1]);
         // A new request retires the previous done
         status[0]   <= set_bits[0] | (status[0] & ~clr_bits[0] & ~req_wr);
      end
   end

   assign result_done = status[`ST_DONE];

   // Read data captured in the setup cycle, valid through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (setup && !pwrite) begin
         case (paddr)
            `OFS_CAP:    prdata <= cap;
            `OFS_ENTRY:  prdata <= entry;
            `OFS_ATTR:   prdata <= attr_table;
            `OFS_TTYPE:  prdata <= {29'h0, ttype};
            `OFS_REQ:    prdata <= {21'h0, req};
            `OFS_RESULT: prdata <= {19'h0, result};
            `OFS_STATUS: prdata <= {28'h0, status};
            default:     prdata <= 32'h0;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cdis_forces_uc: assert property (
      (eval_end && cache_dis && coh && mtype_sup) |=> eff_memtype == 3'h0)
      else $error("cache disable did not force uncacheable");

   a_cdis_coh_only: assert property (
      (eval_end && cache_dis && !coh && is_write && hit) |=>
      result[7] && result[9] == $past(shared))
      else $error("cache disable acted on non-coherent request");

   a_psnp_snoops: assert property (
      (eval_end && snoop_sup && psnp) |=> eff_snoop)
      else $error("page snoop did not force snoop");

   a_snoop_rsvd: assert property (
      (eval_end && !snoop_sup && psnp) |=>
      status[`ST_RSVD] && eff_snoop == $past(req[`REQ_SNOOP]))
      else $error("reserved page snoop mishandled");

   a_mtype_rsvd: assert property (
      (eval_end && !mtype_sup && (ete || cache_dis || attr_table != 32'h0)) |=>
      status[`ST_RSVD] && !result[3])
      else $error("reserved memory type fields not flagged");

   a_hi_rsvd: assert property (
      (eval_end && entry[31:27] != 5'h0) |=> status[`ST_RSVD])
      else $error("reserved entry bits not flagged");

   a_ete_ignored: assert property (
      (eval_end && type_valid && !cache_dis && ete &&
       (ttype == 3'h1 || ttype == 3'h4)) |=>
      eff_memtype == ($past(slot_ok) ? $past(slot_code) : 3'h0))
      else $error("extended enable not ignored");

   a_ete_used: assert property (
      (eval_end && type_valid && !cache_dis && ete && ttype == 3'h2) |=>
      eff_memtype == ($past(leaf_ok) ? $past(leaf_code) : 3'h0))
      else $error("leaf extended type not used");

   a_bad_code: assert property (
      (eval_end && type_valid && !cache_dis && !ete_used &&
       (slot_code == 3'h2 || slot_code == 3'h3)) |=> status[`ST_BADCODE])
      else $error("reserved attribute code not flagged");

   a_write_miss: assert property (
      (eval_end && cache_on && is_write && !hit) |=> result[8] && result[9])
      else $error("write miss did not fill and update memory");

   a_shared_mod: assert property (
      (eval_end && cache_on && is_write && hit && shared &&
       next_type == pmsa_pkg::MT_WB) |=> result[10] && result[11])
      else $error("shared to modified without read invalidation");

   a_nested_gpa: assert property (
      (eval_end && ttype == 3'h3) |=> result[12])
      else $error("nested root not marked guest physical");

   a_req_done: assert property (
      req_wr |=> eval_end ##1 result_done)
      else $error("request did not complete in two cycles");

   c_cdis_write: cover property (eval_end && cache_dis && coh && mtype_sup && is_write);
   c_psnp: cover property (eval_end && snoop_sup && psnp && !req[`REQ_SNOOP]);
   c_ete_nested: cover property (eval_end && ete_used && ttype == 3'h3);
   c_err: cover property (pslverr);

endmodule : pasid_memtype_snoop_attr
`default_nettype wire

// ==== apb_requester.sv ====
// APB requester standing in for software and the requesting devices.
// Assumes tb_top provides hang for a transfer that never completes.
`timescale 1ns/1ps
`default_nettype none
module apb_requester (
   // Clock
   input  wire logic        pclk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'hf;
   end

   // Request held until pready is sampled high
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) tb_top.hang();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released data does not keep its last value
      pwdata  <= ~d;
   endtask : xfer
endmodule : apb_requester
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the memory-type and snoop resolver.
// Assumes the register map and request layout of the resolver header.
`timescale 1ns/1ps
`default_nettype none
`include "pmsa_regs.svh"
module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [2:0]  eff_memtype;
   logic        eff_snoop;
   logic        result_done;
   logic [31:0] res;
   logic [31:0] st;
   int          n_mismatch = 0;
   int          tests_run = 0;

   pasid_memtype_snoop_attr u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .eff_memtype(eff_memtype), .eff_snoop(eff_snoop), .result_done(result_done));
   apb_requester u_req (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .pslverr(pslverr), .prdata(prdata));

   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   task hang;
      n_mismatch++;
      wrap_up();
   endtask : hang

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task chk_pin(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_pin

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      u_req.xfer(1'b1, a, d, r, e);
   endtask : wr

   task rd(input logic [11:0] a, output logic [31:0] r, output logic e);
      u_req.xfer(1'b0, a, 32'h0000_0000, r, e);
   endtask : rd

   function automatic logic [31:0] rq(input logic coh, input logic [2:0] slot,
      input logic [2:0] ext, input logic snp, input logic w, input logic hit,
      input logic sh);
      return {21'h0, sh, hit, w, snp, ext, slot, coh};
   endfunction : rq

   // Done is cleared at the request edge, so look one edge later
   task run(input logic [31:0] q);
      logic e;
      int   i;
      wr(`OFS_REQ, q);
      @(posedge pclk);
      #1;
      for (i = 0; i < 20 && result_done !== 1'b1; i++) begin
         @(posedge pclk);
         #1;
      end
      if (result_done !== 1'b1) hang();
      rd(`OFS_RESULT, res, e);
      rd(`OFS_STATUS, st, e);
   endtask : run

   task t_regs;
      logic [31:0] r;
      logic        e;
      rd(`OFS_CAP, r, e);
      chk_reg(r, 32'h0000_0003);
      rd(`OFS_ENTRY, r, e);
      chk_reg(r, 32'h0000_0000);
      rd(`OFS_ATTR, r, e);
      chk_reg(r, 32'h0000_0000);
      rd(12'h040, r, e);
      chk_pin({3'h0, e}, 4'h1);
      chk_reg(r, 32'h0000_0000);
      wr(`OFS_RESULT, 32'hffff_ffff);
      rd(`OFS_RESULT, r, e);
      chk_reg(r, 32'h0000_0000);
   endtask : t_regs

   // Slots 6 and 7 carry reserved codes
   task t_slots;
      logic [2:0] ex [6];
      int         i;
      ex = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
      wr(`OFS_ATTR, 32'h3276_5410);
      wr(`OFS_TTYPE, 32'h0000_0001);
      for (i = 0; i < 8; i++) begin
         run(rq(1'b1, i[2:0], 3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
         if (i < 6) chk_pin({1'b0, eff_memtype}, {1'b0, ex[i]});
         if (i < 6) chk_pin(res[3:0], {1'b1, ex[i]});
         chk_pin({3'h0, st[`ST_BADCODE]}, {3'h0, i >= 6});
      end
   endtask : t_slots

   task t_ext;
      int t;
      wr(`OFS_ENTRY, 32'h0400_0000);
      for (t = 1; t < 6; t++) begin
         wr(`OFS_TTYPE, 32'(t));
         run(rq(1'b1, 3'h0, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0));
         if (t < 5) chk_pin({1'b0, eff_memtype}, (t == 2 || t == 3) ? 4'h6 : 4'h0);
         chk_pin({3'h0, res[12]}, {3'h0, t == 3});
         chk_pin({3'h0, st[`ST_BADTT]}, {3'h0, t == 5});
      end
      wr(`OFS_TTYPE, 32'h0000_0002);
      wr(`OFS_ENTRY, 32'h0000_0000);
      run(rq(1'b1, 3'h0, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0));
      chk_pin({1'b0, eff_memtype}, 4'h0);
   endtask : t_ext

   // Order {write, hit, shared}; effective type write back
   task t_cache;
      logic [2:0] cs [5];
      logic [6:0] ce [5];
      int         i;
      cs = '{3'b010, 3'b000, 3'b110, 3'b100, 3'b111};
      ce = '{7'h01, 7'h02, 7'h04, 7'h18, 7'h74};
      wr(`OFS_ENTRY, 32'h0400_0000);
      for (i = 0; i < 5; i++) begin
         run(rq(1'b1, 3'h0, 3'h6, 1'b0, cs[i][2], cs[i][1], cs[i][0]));
         chk_reg({25'h0, res[11:5]}, {25'h0, ce[i]});
      end
      wr(`OFS_ENTRY, 32'h0600_0000);
      run(rq(1'b1, 3'h0, 3'h6, 1'b0, 1'b0, 1'b1, 1'b0));
      chk_pin({1'b0, eff_memtype}, 4'h0);
      chk_pin(res[3:0], 4'h8);
      run(rq(1'b0, 3'h0, 3'h6, 1'b0, 1'b1, 1'b1, 1'b1));
      chk_pin({3'h0, res[7]}, 4'h1);
      chk_pin({3'h0, res[3]}, 4'h0);
   endtask : t_cache

   task t_snoop;
      int k;
      for (k = 0; k < 4; k++) begin
         wr(`OFS_ENTRY, {7'h0, k[1], 24'h0});
         run(rq(1'b1, 3'h0, 3'h0, k[0], 1'b0, 1'b0, 1'b0));
         chk_pin({3'h0, eff_snoop}, {3'h0, k[1] | k[0]});
         chk_pin({3'h0, res[4]}, {3'h0, k[1] | k[0]});
      end
   endtask : t_snoop

   // Fields programmed without the matching support are flagged
   task t_fault;
      int k;
      for (k = 0; k < 2; k++) begin
         wr(`OFS_STATUS, 32'h0000_000e);
         wr(`OFS_CAP, k ? 32'h0000_0002 : 32'h0000_0001);
         wr(`OFS_ENTRY, k ? 32'h0200_0000 : 32'h0100_0000);
         run(rq(1'b1, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
         chk_pin({3'h0, st[`ST_RSVD]}, 4'h1);
         if (k == 0) chk_pin({3'h0, eff_snoop}, 4'h0);
         if (k == 1) chk_pin({3'h0, res[3]}, 4'h0);
      end
      wr(`OFS_CAP, 32'h0000_0003);
      wr(`OFS_STATUS, 32'h0000_0001);
      @(posedge pclk);
      #1;
      chk_pin({3'h0, result_done}, 4'h0);
   endtask : t_fault

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      repeat (100000) @(posedge pclk);
      hang();
   end

   initial begin
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_slots();
      t_ext();
      t_cache();
      t_snoop();
      t_fault();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
